// ==== design/csp_port.sv ====
// clocked serial port: control/status and data registers, shift engine, clock pin
// assumes one system clock; pins from the peer are synchronised here
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - end flag set when an eight-bit transfer finishes
// - interrupt request while end flag and end-interrupt enable are both set
// - data register access, reset and stop mode clear end flag
// - receive enable starts clocking serial input bits in
// - after eight received bits receive enable clears and end flag sets
// - transmit enable starts clocking serial output bits out
// - after eight sent bits transmit enable clears and end flag sets
// - receive and transmit enable never both one
// - internal mode drives clock pin, external mode reads it
// - speed code picks divide 20 to 1280, all ones external
// - reset sets speed field to all ones
// - clock pin output when code not all ones, toggles only while enabled
// - reset clears interrupt enable; reset and stop mode clear enables
// - control/status at 0Ah, data at 0Bh
module csp_port
   import csp_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic io_stop_mode_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic irq_out,
   input wire logic shift_clock_pin_in,
   output logic shift_clock_pin_out,
   output logic shift_clock_pin_oe_n_out,
   input wire logic serial_in_pin_in,
   output logic serial_out_pin_out,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   input wire logic rx_ready_in
);
   logic end_flag_q;
   logic eie_q;
   logic re_q;
   logic te_q;
   logic [2:0] ss_q;
   logic [7:0] data_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic [2:0] ck_sync_q;
   logic [1:0] rx_sync_q;
   logic [10:0] div_q;
   logic sclk_q;
   logic [3:0] cnt_q;
   logic txd_q;
   logic oe_n_q;
   csp_state_e state_q;
   // two-entry buffer of received bytes
   logic [7:0] buf_q [2];
   logic [1:0] buf_cnt_q;
   logic rx_valid_q;

   wire ctrl_sel = (addr_in == CSP_CTRL_ADDR);
   wire data_sel = (addr_in == CSP_DATA_ADDR);
   wire ctrl_wr = wr_in & ctrl_sel;
   wire data_wr = wr_in & data_sel;
   wire data_rd = rd_in & data_sel;
   wire ext_mode = (ss_q == CSP_SS_EXT);
   wire active = re_q | te_q;
   wire [11:0] half_ratio = 12'(CSP_BASE_HALF) << ss_q;
   wire int_tick = (div_q == 11'(half_ratio - 12'd1));
   wire ext_rise = ck_sync_q[1] & ~ck_sync_q[2];
   wire ext_fall = ~ck_sync_q[1] & ck_sync_q[2];
   wire rise = ext_mode ? ext_rise : (int_tick & ~sclk_q);
   wire fall = ext_mode ? ext_fall : (int_tick & sclk_q);
   wire shifting = (state_q == CSP_SHIFT);
   wire last_bit = shifting & rise & (cnt_q == 4'(CSP_BITS - 1));
   wire buf_full = (buf_cnt_q == 2'd2);
   wire rx_stall = re_q & buf_full; // receiver holds off while buffer full
   wire buf_push = last_bit & re_q;
   wire buf_pop = rx_valid_out & rx_ready_in;
   wire buf_in = buf_push & ~buf_full;
   wire [1:0] buf_cnt_d = buf_cnt_q + 2'(buf_in) - 2'(buf_pop);
   wire [1:0] buf_slot = buf_cnt_q - 2'(buf_pop);
   wire [7:0] rx_byte = {rx_sync_q[1], data_q[7:1]};
   wire stop = io_stop_mode_in;
   wire start_rx = ctrl_wr & wdata_in[CSP_RE_BIT] & ~te_q;
   wire start_tx = ctrl_wr & wdata_in[CSP_TE_BIT] & ~re_q & ~wdata_in[CSP_RE_BIT];
   wire [7:0] ctrl_view = {end_flag_q, eie_q, re_q, te_q, 1'b0, ss_q};
   wire [7:0] rdata_d = ctrl_sel ? ctrl_view : (data_sel ? data_q : 8'h00);

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ck_sync_q <= 3'h7;
         rx_sync_q <= 2'h0;
      end else begin
         ck_sync_q <= {ck_sync_q[1:0], shift_clock_pin_in};
         rx_sync_q <= {rx_sync_q[0], serial_in_pin_in};
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         eie_q <= 1'b0;
         ss_q <= CSP_SS_RESET;
      end else if (ctrl_wr) begin
         eie_q <= wdata_in[CSP_EIE_BIT];
         ss_q <= wdata_in[2:0];
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         re_q <= 1'b0;
         te_q <= 1'b0;
      end else if (stop) begin
         re_q <= 1'b0;
         te_q <= 1'b0;
      end else if (last_bit) begin
         re_q <= 1'b0;
         te_q <= 1'b0;
      end else if (ctrl_wr && !active) begin
         re_q <= start_rx;
         te_q <= start_tx;
      end
   end

   // set wins over a data-register access in the same cycle
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         end_flag_q <= 1'b0;
      end else if (stop) begin
         end_flag_q <= 1'b0;
      end else if (last_bit) begin
         end_flag_q <= 1'b1;
      end else if (data_wr || data_rd) begin
         end_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         div_q <= 11'h0;
         sclk_q <= 1'b1;
      end else if (!active || ext_mode || rx_stall) begin
         div_q <= 11'h0;
         sclk_q <= 1'b1;
      end else if (int_tick) begin
         div_q <= 11'h0;
         sclk_q <= ~sclk_q;
      end else begin
         div_q <= div_q + 11'd1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= CSP_IDLE;
         cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            CSP_IDLE: begin
               cnt_q <= 4'h0;
               if (active && !stop && !rx_stall) begin
                  state_q <= CSP_SHIFT;
               end
            end
            CSP_SHIFT: begin
               if (stop) begin
                  state_q <= CSP_IDLE;
               end else if (last_bit) begin
                  state_q <= CSP_DONE;
               end else if (rise) begin
                  cnt_q <= cnt_q + 4'd1;
               end
            end
            CSP_DONE: begin
               state_q <= CSP_IDLE;
            end
            default: begin
               state_q <= CSP_IDLE;
            end
         endcase
      end
   end

   // one register holds the byte out and the byte in
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         data_q <= 8'h00;
         txd_q <= 1'b1;
      end else if (data_wr && !active) begin
         data_q <= wdata_in;
      end else if (shifting && te_q && fall) begin
         txd_q <= data_q[0];
      end else if (shifting && rise) begin
         data_q <= {re_q ? rx_sync_q[1] : data_q[0], data_q[7:1]};
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         buf_cnt_q <= 2'h0;
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
         rx_valid_q <= 1'b0;
      end else begin
         // entry 0 always holds the oldest byte, so the output needs no mux
         if (buf_pop) begin
            buf_q[0] <= buf_q[1];
         end
         if (buf_in) begin
            buf_q[buf_slot[0]] <= rx_byte;
         end
         buf_cnt_q <= buf_cnt_d;
         rx_valid_q <= (buf_cnt_d != 2'h0);
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         rdata_q <= rd_in ? rdata_d : 8'h00;
         irq_q <= eie_q & end_flag_q;
         oe_n_q <= ext_mode;
      end
   end

   assign rdata_out = rdata_q;
   assign irq_out = irq_q;
   assign shift_clock_pin_out = sclk_q;
   assign shift_clock_pin_oe_n_out = oe_n_q;
   assign serial_out_pin_out = txd_q;
   assign rx_valid_out = rx_valid_q;
   assign rx_data_out = buf_q[0];

   // measures each half period of the driven shift clock at the pin itself
   logic pin_prev_q;
   logic [11:0] pin_cnt_q;
   wire pin_toggled = (shift_clock_pin_out != pin_prev_q);

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pin_prev_q <= 1'b1;
         pin_cnt_q <= 12'hFFF;
      end else begin
         pin_prev_q <= sclk_q;
         if (!active || ext_mode || rx_stall) begin
            pin_cnt_q <= 12'hFFF;
         end else if (pin_toggled) begin
            pin_cnt_q <= 12'h000;
         end else begin
            pin_cnt_q <= pin_cnt_q + 12'h001;
         end
      end
   end

   a_enables_exclusive: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !(re_q && te_q)) else $error("both enables set");
   a_end_sets_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      last_bit && !stop |=> end_flag_q && !re_q && !te_q) else $error("no end");
   a_irq_follows: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      eie_q && end_flag_q |=> irq_out) else $error("irq missing");
   a_irq_masked: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !eie_q |=> !irq_out) else $error("irq unmasked");
   a_data_clears_ef: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (data_rd || data_wr) && !last_bit |=> !end_flag_q) else $error("flag stays");
   a_stop_clears: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      stop |=> !re_q && !te_q && !end_flag_q) else $error("stop ignored");
   a_pin_dir: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $changed(ss_q) |=> shift_clock_pin_oe_n_out == (ss_q == CSP_SS_EXT)) else $error("pin");
   a_clock_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !active && !$past(active) |-> shift_clock_pin_out) else $error("clock runs");
   a_start_rx: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ctrl_wr && !active && !stop && wdata_in[CSP_RE_BIT] |=> re_q && !te_q)
      else $error("receive not started");
   a_start_tx: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ctrl_wr && !active && !stop && wdata_in[CSP_TE_BIT] && !wdata_in[CSP_RE_BIT]
      |=> te_q && !re_q) else $error("transmit not started");
   a_busy_ignores: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ctrl_wr && active && !last_bit && !stop |=> re_q == $past(re_q) && te_q == $past(te_q))
      else $error("enable changed while busy");
   a_bit_count: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cnt_q <= 4'h7) else $error("bit count overrun");
   a_pin_output: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !ext_mode |=> !shift_clock_pin_oe_n_out) else $error("pin not driven");
   a_ext_clock_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ext_mode && $past(ext_mode) |-> shift_clock_pin_out) else $error("clock out in ext mode");
   a_tx_on_fall: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $past(!ext_mode) && $changed(serial_out_pin_out) |-> !shift_clock_pin_out)
      else $error("data moved off the falling edge");
   a_irq_clears: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !end_flag_q |=> !irq_out) else $error("irq without flag");
   a_ef_holds: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      end_flag_q && !stop && !data_rd && !data_wr |=> end_flag_q) else $error("flag lost");
   a_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !rd_in |=> rdata_out == 8'h00) else $error("read data without strobe");
   a_push_valid: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      buf_in |=> rx_valid_out) else $error("byte not offered");
   a_valid_holds: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
      else $error("offered byte dropped");
   a_half_period: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      pin_toggled && active && !ext_mode
      |-> pin_cnt_q == (12'(CSP_BASE_HALF) << ss_q) - 12'h001) else $error("rate");
endmodule // csp_port
`default_nettype wire

// ==== design/csp_pkg.sv ====
// constants for the clocked serial port: register map, fields, reset values, timing
// assumes a 125 MHz system clock and an 8-bit register port
package csp_pkg;
   localparam logic [7:0] CSP_CTRL_ADDR = 8'h0A;
   localparam logic [7:0] CSP_DATA_ADDR = 8'h0B;
   localparam int CSP_EF_BIT = 7;
   localparam int CSP_EIE_BIT = 6;
   localparam int CSP_RE_BIT = 5;
   localparam int CSP_TE_BIT = 4;
   localparam logic [2:0] CSP_SS_RESET = 3'h7;
   localparam logic [2:0] CSP_SS_EXT = 3'h7;
   localparam int CSP_BASE_RATIO = 20;
   localparam int CSP_BITS = 8;
   localparam int CSP_SYS_PERIOD_NS = 8;
   localparam int CSP_BASE_HALF = CSP_BASE_RATIO / 2;
   typedef enum logic [2:0] {
      CSP_IDLE = 3'b001,
      CSP_SHIFT = 3'b010,
      CSP_DONE = 3'b100
   } csp_state_e;
endpackage

// ==== test/csp_peer_model.sv ====
// peer on the far side of the clocked serial port: one byte each way, lsb first
// assumes the bench resolves the shared clock wire from the output enable
`timescale 1ns/1ps
`default_nettype none
module csp_peer_model (
   input wire logic sck_in,
   input wire logic sdo_in,
   input wire logic [7:0] tx_byte_in,
   output logic sdi_out,
   output logic sck_ext_out
);
   logic [7:0] rx_q;
   int bit_n = 0;
   realtime last_t = 0.0;
   realtime period = 0.0;
   initial sdi_out = 1'b1;
   initial sck_ext_out = 1'b1;
   always @(negedge sck_in) sdi_out = tx_byte_in[bit_n];
   always @(posedge sck_in) begin
      rx_q = {sdo_in, rx_q[7:1]};
      period = $realtime - last_t;
      last_t = $realtime;
      bit_n = (bit_n + 1) % 8;
      // hold time over: the line flips so a late sample shows
      if (bit_n == 0) sdi_out <= #40 ~sdi_out;
   end
   // period of 32 system cycles, idles high between frames
   task automatic run_ext_clock();
      repeat (8) begin
         sck_ext_out = 1'b0;
         #128;
         sck_ext_out = 1'b1;
         #128;
      end
   endtask
endmodule // csp_peer_model
`default_nettype wire

// ==== test/tb.sv ====
// bench for the clocked serial port: register tasks, scenarios, verdict
// assumes csp_pkg, csp_port and csp_peer_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
   import csp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic stop = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rdy = 1'b0;
   logic [7:0] peer_tx = 8'h3C;
   logic [7:0] v;
   wire [7:0] rdata, rx_data;
   wire irq, sck_dev, oe_n, sdo, rx_valid, sdi, sck_ext;
   wire sck = (oe_n === 1'b0) ? sck_dev : sck_ext;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   csp_port dut (.sys_clk_in(clk), .reset_in(rst), .io_stop_mode_in(stop), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
      .shift_clock_pin_in(sck), .shift_clock_pin_out(sck_dev),
      .shift_clock_pin_oe_n_out(oe_n), .serial_in_pin_in(sdi), .serial_out_pin_out(sdo),
      .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_ready_in(rdy));
   csp_peer_model peer (.sck_in(sck), .sdo_in(sdo), .tx_byte_in(peer_tx), .sdi_out(sdi),
      .sck_ext_out(sck_ext));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // polls status until the end flag shows, bounded
   task automatic wait_end(output logic [7:0] d);
      int n = 0;
      d = 8'h00;
      while (d[CSP_EF_BIT] !== 1'b1 && n < 6000) begin
         bus_rd(CSP_CTRL_ADDR, d);
         n++;
      end
      chk(n < 6000, 1'b1);
   endtask
   // takes the oldest buffered byte, then checks whether one is still offered
   task automatic pop_byte(input logic more);
      @(posedge clk);
      rdy <= 1'b1;
      @(posedge clk);
      rdy <= 1'b0;
      @(negedge clk);
      chk(rx_valid, more);
   endtask
   task automatic t_reset();
      bus_rd(CSP_CTRL_ADDR, v);
      chk(v, 8'h07);
      chk(oe_n, 1'b1);
      chk(irq, 1'b0);
      bus_rd(8'h0C, v);
      chk(v, 8'h00);
   endtask
   task automatic t_tx_rates();
      logic [7:0] d;
      for (int s = 0; s < 7; s++) begin
         d = 8'h5A ^ 8'(s << 5);
         bus_wr(CSP_DATA_ADDR, d);
         bus_wr(CSP_CTRL_ADDR, 8'h50 | 8'(s));
         bus_rd(CSP_CTRL_ADDR, v);
         chk(v, 8'h50 | 8'(s));
         chk(oe_n, 1'b0);
         wait_end(v);
         chk(v, 8'hC0 | 8'(s));
         chk(irq, 1'b1);
         chk(peer.rx_q, d);
         chk(int'(peer.period), (CSP_BASE_RATIO << s) * CSP_SYS_PERIOD_NS);
      end
      bus_wr(CSP_DATA_ADDR, 8'h00);
      bus_rd(CSP_CTRL_ADDR, v);
      chk(v, 8'h46);
      chk(irq, 1'b0);
   endtask
   task automatic t_rx();
      bus_wr(CSP_CTRL_ADDR, 8'h21);
      wait_end(v);
      chk(v, 8'h81);
      chk(irq, 1'b0);
      bus_rd(CSP_DATA_ADDR, v);
      chk(v, 8'h3C);
      peer_tx <= 8'hC3;
      bus_wr(CSP_CTRL_ADDR, 8'h31);
      bus_rd(CSP_CTRL_ADDR, v);
      chk(v, 8'h21);
      wait_end(v);
      chk(rx_valid, 1'b1);
      chk(rx_data, 8'h3C);
      pop_byte(1'b1);
      chk(rx_data, 8'hC3);
      pop_byte(1'b0);
      @(posedge clk);
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
      bus_rd(CSP_CTRL_ADDR, v);
      chk(v, 8'h01);
   endtask
   task automatic t_ext();
      bus_wr(CSP_DATA_ADDR, 8'h96);
      bus_wr(CSP_CTRL_ADDR, 8'h17);
      bus_rd(CSP_CTRL_ADDR, v);
      chk(oe_n, 1'b1);
      peer.run_ext_clock();
      wait_end(v);
      chk(v, 8'h87);
      chk(peer.rx_q, 8'h96);
      // second reset while idle, with end flag, interrupt enable and an internal rate set
      bus_wr(CSP_CTRL_ADDR, 8'h40);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus_rd(CSP_CTRL_ADDR, v);
      chk(v, 8'h07);
      chk(oe_n, 1'b1);
      chk(irq, 1'b0);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      peer.bit_n = 0;
      t_reset();
      t_tx_rates();
      t_rx();
      t_ext();
      print_verdict();
   end
endmodule // tb
`default_nettype wire
